// >>> include/tw_pkg.sv
// shared constants and types for the two-wire memory slave
package tw_pkg;

    // ========================================================
    // array geometry
    localparam int TW_AW = 11;
    localparam int TW_DW = 8;
    localparam int TW_DEPTH = 2048;
    localparam int TW_ROW_W = 4;
    localparam logic [7:0] TW_ERASED = 8'hff;

    // ========================================================
    // select byte and bit counting
    // device type code: arbitrary neutral value
    localparam logic [3:0] TW_DEV_TYPE = 4'h5;
    localparam logic [3:0] TW_LAST_BIT = 4'h7;
    localparam logic [3:0] TW_BYTE_BITS = 4'h8;
    localparam logic [4:0] TW_IDX_DONE = 5'h10;

    // ========================================================
    // program cycle timing
    localparam int TW_CLK_HZ = 20_000_000;
    localparam int TW_PROG_MS = 5;
    localparam int TW_PROG_LONG_MS = 20;
    localparam int TW_PROG_CYC = TW_CLK_HZ / 1000 * TW_PROG_MS;
    localparam int TW_PROG_LONG_CYC = TW_CLK_HZ / 1000 * TW_PROG_LONG_MS;
    localparam int TW_TMR_W = 21;

    // ========================================================
    // state and byte kind
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_PROG
    } tw_state_type;

    typedef enum logic [1:0] {
        K_SEL, K_AHI, K_ALO, K_DATA
    } tw_kind_type;

endpackage : tw_pkg

// >>> logic/tw_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module tw_sync
    import tw_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tw_sync_type;

    tw_sync_type r_q;
    tw_sync_type r_d;

    // ========================================================
    // first flop feeds only the second
    always_comb begin
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_q.s1 <= RST_VAL;
            r_q.s2 <= RST_VAL;
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.s2;

endmodule : tw_sync

// >>> logic/tw_mem.sv
// memory array with registered read port
`timescale 1ns/1ps
module tw_mem
    import tw_pkg::*;
#(
    parameter int AW = TW_AW,
    parameter int DW = TW_DW,
    parameter int DEPTH = TW_DEPTH
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] mem [DEPTH];

    // ========================================================
    // erased contents at start
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = TW_ERASED;
        end
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : tw_mem

// >>> logic/tw_slave.sv
// two-wire serial memory slave, 2048 x 8
// What this block does
// - transmitter releases data after eight bits; receiver pulls low on ninth
// - data sampled on rising clock; master changes it only while low
// - select byte: type code, three chip selects, direction bit
// - two address bytes, high first, bits 10..8 pick a block
// - write select is acknowledged, then two address bytes precede data
// - protect high from start to second address byte blocks write
// - single byte write is one acknowledged byte then stop
// - page write carries up to sixteen bytes within one row
// - after each written byte only the low four address bits count
// - stop after write starts programming; bus ignored until done
// - write touching both eight byte halves takes twenty milliseconds
// - select is not acknowledged while programming, acknowledged after
// - array starts with every byte all ones
// - eleven bit address counter increments after each byte read
// - read select sends byte at counter, then increments counter
// - random read loads address by dummy write then restart read
// - master acknowledge continues sequential read; no acknowledge ends it
// - read counter wraps from top address to zero
// - missing master acknowledge on ninth bit returns to idle
// - chip select pins must match select byte bits 3..1
// - unconnected write protect input reads as low; the code has no pull, only a low reset value in the pin synchroniser
`timescale 1ns/1ps
module tw_slave
    import tw_pkg::*;
#(
    parameter int PROG_CYC = TW_PROG_CYC,
    parameter int PROG_LONG_CYC = TW_PROG_LONG_CYC,
    parameter logic [3:0] DEV_TYPE = TW_DEV_TYPE
) (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    input wire logic WRITE_PROTECT_INPUT,
    input wire logic [2:0] CHIP_SELECT_PINS,
    output logic BUSY
);

    localparam logic [TW_TMR_W-1:0] LIM_SHORT = TW_TMR_W'(PROG_CYC - 1);
    localparam logic [TW_TMR_W-1:0] LIM_LONG =
        TW_TMR_W'(PROG_LONG_CYC - 1);

    typedef struct packed {
        tw_state_type st;
        tw_kind_type kind;
        logic [3:0] bit_cnt;
        logic [7:0] sh;
        logic ack;
        logic ph;
        logic rw;
        logic wp_seen;
        logic [TW_AW-1:0] addr;
        logic [15:0][7:0] page;
        logic [15:0] valid;
        logic [4:0] idx;
        logic [TW_TMR_W-1:0] tmr;
        logic [TW_TMR_W-1:0] lim;
        logic scl_p;
        logic sda_p;
        logic oe_n;
    } tw_regs_type;

    tw_regs_type q;
    tw_regs_type n;

    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic [2:0] cs_s;
    logic [7:0] rdata;
    logic [7:0] rx_byte;
    logic [7:0] tx_src;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic ack_c;
    logic long_c;
    logic mem_we;

    // ========================================================
    // pin synchronisers
    tw_sync #(.W(2), .RST_VAL(2'h3)) u_bus_sync (
        .clk(REF_CLK),
        .nrst(NRST),
        .d({SCL, SDA_IN}),
        .q({scl_s, sda_s})
    );

    // protect pin synchroniser resets to low; no internal pull on the pin
    tw_sync #(.W(4), .RST_VAL(4'h0)) u_pin_sync (
        .clk(REF_CLK),
        .nrst(NRST),
        .d({WRITE_PROTECT_INPUT, CHIP_SELECT_PINS}),
        .q({wp_s, cs_s})
    );

    // ========================================================
    // memory array
    assign mem_we = (q.st == ST_PROG) && !q.idx[4] &&
        q.valid[q.idx[3:0]];

    tw_mem u_mem (
        .clk(REF_CLK),
        .we(mem_we),
        .waddr({q.addr[TW_AW-1:TW_ROW_W], q.idx[3:0]}),
        .wdata(q.page[q.idx[3:0]]),
        .raddr(q.addr),
        .rdata(rdata)
    );

    // ========================================================
    // bus events
    assign scl_rise = scl_s && !q.scl_p;
    assign scl_fall = !scl_s && q.scl_p;
    assign start_c = scl_s && q.scl_p && q.sda_p && !sda_s;
    assign stop_c = scl_s && q.scl_p && !q.sda_p && sda_s;
    assign rx_byte = {q.sh[6:0], sda_s};
    assign tx_src = (q.bit_cnt == 4'h0) ? rdata : q.sh;
    assign long_c = (|q.valid[7:0]) && (|q.valid[15:8]);

    // acknowledge decision for the byte now completing
    always_comb begin
        unique case (q.kind)
            K_SEL: begin
                ack_c = (rx_byte[7:1] == {DEV_TYPE, cs_s});
            end
            K_DATA: begin
                ack_c = !q.wp_seen;
            end
            default: begin
                ack_c = 1'b1;
            end
        endcase
    end

    // ========================================================
    // next state
    always_comb begin
        n = q;
        n.scl_p = scl_s;
        n.sda_p = sda_s;
        if (q.st == ST_PROG) begin
            // bus fully ignored while programming
            n.oe_n = 1'b1;
            n.tmr = q.tmr + TW_TMR_W'(1);
            if (q.idx != TW_IDX_DONE) begin
                n.idx = q.idx + 5'h01;
            end
            if (q.tmr == q.lim) begin
                n.st = ST_IDLE;
                n.valid = '0;
            end
        end else if (start_c) begin
            // start or restart; address counter kept
            n.st = ST_RX;
            n.kind = K_SEL;
            n.bit_cnt = 4'h0;
            n.oe_n = 1'b1;
            n.wp_seen = wp_s;
        end else if (stop_c) begin
            n.oe_n = 1'b1;
            if ((q.valid != '0) && !q.rw) begin
                n.st = ST_PROG;
                n.tmr = '0;
                n.idx = 5'h00;
                n.lim = long_c ? LIM_LONG : LIM_SHORT;
            end else begin
                n.st = ST_IDLE;
            end
        end else begin
            if (wp_s && (q.st == ST_RX || q.st == ST_ACK) &&
                (q.kind != K_DATA)) begin
                n.wp_seen = 1'b1;
            end
            unique case (q.st)
                ST_IDLE, ST_PROG: begin
                    n.oe_n = 1'b1;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        n.sh = rx_byte;
                        n.bit_cnt = q.bit_cnt + 4'h1;
                        if (q.bit_cnt == TW_LAST_BIT) begin
                            n.st = ST_ACK;
                            n.ph = 1'b0;
                            n.ack = ack_c;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall && !q.ph) begin
                        n.ph = 1'b1;
                        n.oe_n = !q.ack;
                    end else if (scl_fall) begin
                        n.oe_n = 1'b1;
                        n.st = ST_RX;
                        n.bit_cnt = 4'h0;
                        unique case (q.kind)
                            K_SEL: begin
                                n.rw = q.sh[0];
                                if (!q.ack) begin
                                    n.st = ST_IDLE;
                                end else if (q.sh[0]) begin
                                    // first read bit at this fall
                                    n.st = ST_TX;
                                    n.oe_n = rdata[7];
                                    n.sh = {rdata[6:0], 1'b0};
                                    n.bit_cnt = 4'h1;
                                end else begin
                                    n.kind = K_AHI;
                                end
                            end
                            K_AHI: begin
                                n.addr[10:8] = q.sh[2:0];
                                n.kind = K_ALO;
                            end
                            K_ALO: begin
                                n.addr[7:0] = q.sh;
                                n.kind = K_DATA;
                                n.valid = '0;
                            end
                            K_DATA: begin
                                if (q.ack) begin
                                    // page latch, row wrap
                                    n.page[q.addr[3:0]] = q.sh;
                                    n.valid[q.addr[3:0]] = 1'b1;
                                    n.addr[3:0] = q.addr[3:0] + 4'h1;
                                end
                            end
                        endcase
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (q.bit_cnt == TW_BYTE_BITS) begin
                            n.oe_n = 1'b1;
                            n.st = ST_MACK;
                        end else begin
                            n.oe_n = tx_src[7];
                            n.sh = {tx_src[6:0], 1'b0};
                            n.bit_cnt = q.bit_cnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        // counter wraps at top
                        n.addr = q.addr + TW_AW'(1);
                        n.bit_cnt = 4'h0;
                        n.st = sda_s ? ST_IDLE : ST_TX;
                    end
                end
            endcase
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            q <= '0;
            q.oe_n <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ========================================================
    // outputs
    assign SDA_OUT = 1'b0;
    assign SDA_OE_N = q.oe_n;
    assign BUSY = (q.st == ST_PROG);

    // ========================================================
    // checks
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);

    a_wp_data_nak: assert property (
        (q.st == ST_ACK && q.kind == K_DATA && q.wp_seen) |-> q.oe_n)
        else $error("protected data byte acknowledged");

    a_wp_no_latch: assert property (
        (q.st == ST_RX && q.kind == K_DATA && q.wp_seen) |->
            (q.valid == '0))
        else $error("protected data byte latched");

    a_row_wrap_inc: assert property (
        (q.st == ST_ACK && q.ph && q.kind == K_DATA && q.ack &&
            scl_fall && !start_c && !stop_c) |=>
            (q.addr[10:4] == $past(q.addr[10:4])) &&
            (q.addr[3:0] == $past(q.addr[3:0]) + 4'h1))
        else $error("write address did not step within row");

    a_prog_quiet: assert property (
        (q.st == ST_PROG) |=> q.oe_n)
        else $error("data line driven while programming");

    a_prog_end: assert property (
        (q.st == ST_PROG && q.tmr == q.lim) |=> (q.st == ST_IDLE))
        else $error("program cycle did not end at its limit");

    a_long_prog: assert property (
        (q.st != ST_PROG && stop_c && !start_c && q.valid != '0 &&
            !q.rw && long_c) |=> (q.st == ST_PROG && q.lim == LIM_LONG))
        else $error("two-half write not given long program time");

    a_sel_match: assert property (
        (q.st == ST_ACK && q.kind == K_SEL && !q.ph && scl_fall &&
            !start_c && !stop_c && q.ack) |=> !q.oe_n)
        else $error("matching select byte not acknowledged");

    a_mack_idle: assert property (
        (q.st == ST_MACK && scl_rise && sda_s && !start_c && !stop_c)
            |=> (q.st == ST_IDLE) ##1 q.oe_n)
        else $error("read did not stop on missing acknowledge");

    a_seq_cont: assert property (
        (q.st == ST_MACK && scl_rise && !sda_s && !start_c && !stop_c)
            |=> (q.st == ST_TX && q.bit_cnt == 4'h0))
        else $error("acknowledged read byte did not continue");

    a_wsel_addr: assert property (
        (q.st == ST_ACK && q.ph && q.kind == K_SEL && q.ack &&
            !q.sh[0] && scl_fall && !start_c && !stop_c) |=>
            (q.st == ST_RX && q.kind == K_AHI))
        else $error("write select not followed by address phase");

    a_read_inc: assert property (
        (q.st == ST_MACK && scl_rise && !start_c && !stop_c) |=>
            (q.addr == TW_AW'($past(q.addr) + TW_AW'(1))))
        else $error("read counter did not advance by one");

endmodule : tw_slave

// >>> sim/tw_master.sv
// two-wire bus master model for the memory slave
`timescale 1ns/1ps
module tw_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low,
    output logic res_stb,
    output logic [8:0] res_val
);
    // ========================================================
    // bit level
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        res_stb = 1'b0;
        res_val = '0;
    end

    task automatic hc(input int n);
        repeat (n) @(posedge clk);
    endtask : hc

    // data set while clock low, released just after the fall
    task automatic bit_out(input logic b);
        sda_low <= ~b;
        hc(5);
        scl <= 1'b1;
        hc(10);
        scl <= 1'b0;
        hc(1);
        sda_low <= 1'b0;
        hc(4);
    endtask : bit_out

    task automatic bit_in(output logic b);
        sda_low <= 1'b0;
        hc(5);
        scl <= 1'b1;
        hc(5);
        b = sda;
        hc(5);
        scl <= 1'b0;
        hc(5);
    endtask : bit_in

    task automatic post(input logic [8:0] v);
        res_val <= v;
        res_stb <= 1'b1;
        hc(1);
        res_stb <= 1'b0;
    endtask : post

    // ========================================================
    // framing and bytes
    task automatic start();
        sda_low <= 1'b0;
        hc(5);
        scl <= 1'b1;
        hc(10);
        sda_low <= 1'b1;
        hc(10);
        scl <= 1'b0;
        hc(5);
    endtask : start

    task automatic stop();
        sda_low <= 1'b1;
        hc(5);
        scl <= 1'b1;
        hc(10);
        sda_low <= 1'b0;
        hc(10);
    endtask : stop

    task automatic wr_byte(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(a);
        post({a, 8'h00});
    endtask : wr_byte

    task automatic rd_byte(input logic mack);
        logic [7:0] d;
        logic b;
        d = '0;
        for (int i = 0; i < 8; i++) begin
            bit_in(b);
            d = {d[6:0], b};
        end
        bit_out(~mack);
        post({1'b0, d});
    endtask : rd_byte
endmodule : tw_master

// >>> sim/tw_slave_tb_top.sv
// self-checking testbench for the two-wire memory slave
`timescale 1ns/1ps
module tw_slave_tb_top
    import tw_pkg::*;
;
    // ========================================================
    // environment
    localparam int PC = 400;
    localparam int PLC = 800;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic wp = 1'b0;
    logic [2:0] cs = 3'h0;
    logic scl, m_low, sda_out, sda_oe_n, busy, res_stb, sda_w;
    logic [8:0] res_val;
    logic [8:0] exp_q[$];
    logic [7:0] mem [0:2047];
    logic [10:0] a;
    logic [31:0] rs = 32'd90;
    int err_total = 0;
    int n_tests = 0;
    int bcnt = 0;
    int blen = 0;

    always #25 ref_clk = ~ref_clk;
    assign sda_w = (sda_oe_n ? 1'b1 : sda_out) & ~m_low;

    tw_slave #(.PROG_CYC(PC), .PROG_LONG_CYC(PLC)) i_tw_slave (
        .REF_CLK(ref_clk), .NRST(nrst), .SCL(scl), .SDA_IN(sda_w),
        .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
        .WRITE_PROTECT_INPUT(wp), .CHIP_SELECT_PINS(cs), .BUSY(busy)
    );
    tw_master i_tw_master (
        .clk(ref_clk), .sda(sda_w), .scl(scl), .sda_low(m_low),
        .res_stb(res_stb), .res_val(res_val)
    );

    // ========================================================
    // helpers
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs

    task automatic check(input logic [15:0] seen, exp, input string s);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s exp %h seen %h", s, exp, seen);
        end
    endtask : check

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // result watcher
    always @(posedge ref_clk) begin
        if (res_stb === 1'b1) begin
            if (exp_q.size() == 0) begin
                exp_q.push_back(9'bx);
            end
            check(16'(res_val), 16'(exp_q.pop_front()), "bus");
        end
    end

    // program cycle length
    always @(posedge ref_clk) begin
        if (busy === 1'b1) begin
            bcnt <= bcnt + 1;
        end else if (bcnt != 0) begin
            blen <= bcnt;
            bcnt <= 0;
        end
    end

    // ========================================================
    // bus sequences
    task automatic wb(input logic [7:0] d, input logic ack);
        exp_q.push_back({~ack, 8'h00});
        i_tw_master.wr_byte(d);
    endtask : wb

    task automatic rb(input logic [7:0] d, input logic mack);
        exp_q.push_back({1'b0, d});
        i_tw_master.rd_byte(mack);
    endtask : rb

    task automatic sel(input logic rw, input logic ack);
        wb({TW_DEV_TYPE, cs, rw}, ack);
    endtask : sel

    task automatic set_addr(input logic [10:0] ad, input logic wpm);
        i_tw_master.start();
        sel(1'b0, 1'b1);
        if (wpm) begin
            wp <= 1'b1;
        end
        wb({5'h00, ad[10:8]}, 1'b1);
        if (wpm) begin
            wp <= 1'b0;
        end
        wb(ad[7:0], 1'b1);
    endtask : set_addr

    task automatic rd_seq(input logic [10:0] ad, input int n);
        set_addr(ad, 1'b0);
        i_tw_master.start();
        sel(1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            rb(mem[ad + 11'(i)], i != n - 1);
        end
        i_tw_master.stop();
    endtask : rd_seq

    task automatic wr_page(input logic [10:0] ad, input int n,
                           input logic ok, input logic wpm);
        logic [7:0] d;
        set_addr(ad, wpm);
        for (int i = 0; i < n; i++) begin
            d = 8'(xs());
            wb(d, ok);
            if (ok) begin
                mem[{ad[10:4], ad[3:0] + 4'(i)}] = d;
            end
        end
        i_tw_master.stop();
    endtask : wr_page

    task automatic prog_check(input int len);
        i_tw_master.start();
        sel(1'b0, 1'b0);
        i_tw_master.stop();
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) begin
            @(posedge ref_clk);
        end
        repeat (2) @(posedge ref_clk);
        check(16'(blen >= len && blen <= len + 2), 16'h1, "time");
        i_tw_master.start();
        sel(1'b0, 1'b1);
        i_tw_master.stop();
    endtask : prog_check

    // ========================================================
    // tests
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = TW_ERASED;
        end
        repeat (3) @(posedge ref_clk);
        check(16'({sda_oe_n, busy}), 16'h2, "reset");
        nrst <= 1'b1;
        cs <= 3'(xs());
        repeat (4) @(posedge ref_clk);
        rd_seq(11'(xs()), 1);
        done("erased read");
        a = {7'(xs()), 4'he};
        wr_page(a, 18, 1'b1, 1'b0);
        prog_check(PLC);
        rd_seq({a[10:4], 4'h0}, 16);
        done("page write");
        a = {7'(xs()), 4'h2};
        wr_page(a, 1, 1'b1, 1'b0);
        prog_check(PC);
        rd_seq(a, 1);
        done("byte write");
        for (int v = 0; v < 2; v++) begin
            wp <= (v == 0);
            wr_page(a, 2, 1'b0, v == 1);
            wp <= 1'b0;
            repeat (20) @(posedge ref_clk);
            check(16'(busy), 16'h0, "busy");
            rd_seq(a, 2);
        end
        done("write protect");
        rd_seq(11'h7ff, 2);
        i_tw_master.start();
        sel(1'b1, 1'b1);
        rb(mem[11'h001], 1'b0);
        wb(8'hff, 1'b0);
        i_tw_master.stop();
        done("wrap and current read");
        for (int v = 0; v < 4; v++) begin
            i_tw_master.start();
            wb({TW_DEV_TYPE ^ {v[1], 3'h0}, cs ^ {2'h0, ~v[1]}, v[0]},
               1'b0);
            wb(8'h00, 1'b0);
            i_tw_master.stop();
        end
        rd_seq(a, 1);
        done("select mismatch");
        summarize();
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        err_total++;
        summarize();
    end
endmodule : tw_slave_tb_top
